/* File: design/rtcs_bcd_counter.sv */
// two digit bcd counter that runs 00 to 59 and can be loaded
`timescale 1ns/100ps
`include "rtcs_consts.svh"

module rtcs_bcd_counter (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic inc,
  input wire logic load,
  input wire logic [6:0] load_val,
  output logic [6:0] val,
  output logic wrap
);

  logic [6:0] val_q;
  logic [6:0] val_d;

  // tens in bits 6..4, units in bits 3..0
  always_comb begin
    val_d = val_q;
    if (val_q[3:0] == `RTCS_BCD_UNITS_MAX) begin
      val_d[3:0] = 4'h0;
      if (val_q[6:4] == `RTCS_BCD_TENS_MAX) begin
        val_d[6:4] = 3'h0;
      end else begin
        val_d[6:4] = val_q[6:4] + 3'h1;
      end
    end else begin
      val_d[3:0] = val_q[3:0] + 4'h1;
    end
  end

  // a host write wins over a tick in the same cycle; the tick is then lost
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      val_q <= `RTCS_RESET_BCD;
    end else if (load) begin
      val_q <= load_val;
    end else if (inc) begin
      val_q <= val_d;
    end
  end

  assign val = val_q;
  assign wrap = inc & ~load & (val_q[3:0] == `RTCS_BCD_UNITS_MAX)
    & (val_q[6:4] == `RTCS_BCD_TENS_MAX);

endmodule

/* File: design/rtcs_consts.svh */
// constants for the rtc status, restart, seconds and minutes block
`ifndef RTCS_CONSTS_SVH
`define RTCS_CONSTS_SVH

`define RTCS_OFS_STATUS 8'h03
`define RTCS_OFS_RESTART 8'h04
`define RTCS_OFS_SECONDS 8'h08
`define RTCS_OFS_MINUTES 8'h09

`define RTCS_ST_NV_BUSY 7
`define RTCS_ST_POWER_UP 5
`define RTCS_ST_RECOVERY 4
`define RTCS_ST_SUPPLY2 3
`define RTCS_ST_SUPPLY1 2
`define RTCS_RST_RESTART 4

`define RTCS_RESET_POWER_UP 1'b1
`define RTCS_RESET_FLAG 1'b0
`define RTCS_RESET_BCD 7'h00
`define RTCS_BCD_UNITS_MAX 4'h9
`define RTCS_BCD_TENS_MAX 3'h5

`define RTCS_BITS_PER_BYTE 4'h8
// bus address of the slave; the value is arbitrary
`define RTCS_DEV_ADDR 7'h2C

`endif

/* File: design/rtcs_pkg.sv */
// types for the rtc status, restart, seconds and minutes block
package rtcs_pkg;

  typedef enum logic [3:0] {
    RTCS_IDLE,
    RTCS_ADDR,
    RTCS_ADDR_ACK,
    RTCS_PTR,
    RTCS_PTR_ACK,
    RTCS_WR,
    RTCS_WR_ACK,
    RTCS_RD,
    RTCS_RD_ACK
  } rtcs_link_state_t;

endpackage

/* File: design/rtcs_top.sv */
// two-wire slave with status, restart, seconds and minutes registers
`timescale 1ns/100ps
`include "rtcs_consts.svh"

// Notes on behaviour
// [RULE1] watch registers hold bcd, tens high
// [RULE2] seconds count 0 to 59, bit 7 zero
// [RULE3] minutes count 0 to 59, bit 7 zero
// [RULE4] recovery flag shows self-recovery or system reset
// [RULE5] unimplemented bits always read as zero
// [RULE6] writing one to restart bit restarts logic
module rtcs_top #(
  parameter logic [6:0] DEV_ADDR = `RTCS_DEV_ADDR
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic watch_tick,
  input wire logic nonvolatile_write_in_progress,
  input wire logic self_recovery_event,
  input wire logic supply_low_first_event,
  input wire logic supply_low_second_event,
  output logic minutes_carry,
  output logic logic_restart
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus conditions

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  assign scl_rise = scl_sync_q[1] & ~scl_prev_q;
  assign scl_fall = ~scl_sync_q[1] & scl_prev_q;
  // data moving while the clock is high marks start and stop
  assign bus_start = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
  assign bus_stop = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // register state

  logic power_up_flag_q;
  logic recovery_reset_flag_q;
  logic supply_low_second_flag_q;
  logic supply_low_first_flag_q;
  logic nv_busy_q;
  logic [6:0] seconds_val;
  logic [6:0] minutes_val;
  logic seconds_wrap;
  logic minutes_wrap;
  logic wr_stb;
  logic [7:0] ptr_q;
  logic [7:0] shift_q;
  logic restart_req;
  logic load_seconds;
  logic load_minutes;

  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    logic [7:0] r;
    r = 8'h00;
    case (addr)
      `RTCS_OFS_STATUS: begin
        r[`RTCS_ST_NV_BUSY] = nv_busy_q;
        r[`RTCS_ST_POWER_UP] = power_up_flag_q;
        r[`RTCS_ST_RECOVERY] = recovery_reset_flag_q; // RULE4
        r[`RTCS_ST_SUPPLY2] = supply_low_second_flag_q;
        r[`RTCS_ST_SUPPLY1] = supply_low_first_flag_q;
      end
      `RTCS_OFS_SECONDS: r = {1'b0, seconds_val}; // RULE2
      `RTCS_OFS_MINUTES: r = {1'b0, minutes_val}; // RULE3
      // restart bit is a one-shot and reads zero, as do gaps in the map
      default: r = 8'h00; // RULE5
    endcase
    return r;
  endfunction

  function automatic logic wr_hit(input logic [7:0] addr);
    return wr_stb && (ptr_q == addr);
  endfunction

  // flags set by hardware, cleared by writing 0; a set wins over a clear
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    return set | (cur & ~clr);
  endfunction

  // the helpers read module state that is not in their arguments, so only a
  // process that tracks everything it reads may call them between clock edges
  always_comb begin
    restart_req = wr_hit(`RTCS_OFS_RESTART) && shift_q[`RTCS_RST_RESTART]; // RULE6
    load_seconds = wr_hit(`RTCS_OFS_SECONDS);
    load_minutes = wr_hit(`RTCS_OFS_MINUTES);
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      nv_busy_q <= `RTCS_RESET_FLAG;
    end else begin
      nv_busy_q <= nonvolatile_write_in_progress;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      power_up_flag_q <= `RTCS_RESET_POWER_UP;
      recovery_reset_flag_q <= `RTCS_RESET_FLAG;
      supply_low_second_flag_q <= `RTCS_RESET_FLAG;
      supply_low_first_flag_q <= `RTCS_RESET_FLAG;
    end else begin
      power_up_flag_q <= flag_next(power_up_flag_q, 1'b0,
        wr_hit(`RTCS_OFS_STATUS) && !shift_q[`RTCS_ST_POWER_UP]);
      recovery_reset_flag_q <= flag_next(recovery_reset_flag_q,
        self_recovery_event | restart_req,
        wr_hit(`RTCS_OFS_STATUS) && !shift_q[`RTCS_ST_RECOVERY]); // RULE4 RULE6
      supply_low_second_flag_q <= flag_next(supply_low_second_flag_q, supply_low_second_event,
        wr_hit(`RTCS_OFS_STATUS) && !shift_q[`RTCS_ST_SUPPLY2]);
      supply_low_first_flag_q <= flag_next(supply_low_first_flag_q, supply_low_first_event,
        wr_hit(`RTCS_OFS_STATUS) && !shift_q[`RTCS_ST_SUPPLY1]);
    end
  end

  // restart goes out to the rest of the clock as a one-cycle request
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      logic_restart <= 1'b0;
      minutes_carry <= 1'b0;
    end else begin
      logic_restart <= restart_req; // RULE6
      minutes_carry <= minutes_wrap;
    end
  end

  rtcs_bcd_counter u_seconds (
    .mclk(mclk),
    .resetn(resetn),
    .inc(watch_tick),
    .load(load_seconds),
    .load_val(shift_q[6:0]),
    .val(seconds_val),
    .wrap(seconds_wrap)
  ); // RULE1 RULE2

  rtcs_bcd_counter u_minutes (
    .mclk(mclk),
    .resetn(resetn),
    .inc(seconds_wrap),
    .load(load_minutes),
    .load_val(shift_q[6:0]),
    .val(minutes_val),
    .wrap(minutes_wrap)
  ); // RULE1 RULE3

  ////////////////////////////////////////////////////////////////////////////////
  // two-wire slave: address, pointer, then data with pointer auto-increment

  rtcs_pkg::rtcs_link_state_t st_q;
  logic [3:0] bit_cnt_q;
  logic read_mode_q;
  logic nack_q;
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = read_reg(ptr_q);
  end
  assign wr_stb = (st_q == rtcs_pkg::RTCS_WR) && scl_fall && (bit_cnt_q == `RTCS_BITS_PER_BYTE);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= rtcs_pkg::RTCS_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      read_mode_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      st_q <= rtcs_pkg::RTCS_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      st_q <= rtcs_pkg::RTCS_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (st_q)
        rtcs_pkg::RTCS_ADDR, rtcs_pkg::RTCS_PTR, rtcs_pkg::RTCS_WR: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_sync_q[1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == `RTCS_BITS_PER_BYTE) begin
            bit_cnt_q <= 4'h0;
            if (st_q == rtcs_pkg::RTCS_ADDR) begin
              // a foreign address leaves the slave silent until the next start
              if (shift_q[7:1] == DEV_ADDR) begin
                sda_oe <= 1'b1;
                read_mode_q <= shift_q[0];
                st_q <= rtcs_pkg::RTCS_ADDR_ACK;
              end else begin
                st_q <= rtcs_pkg::RTCS_IDLE;
              end
            end else if (st_q == rtcs_pkg::RTCS_PTR) begin
              sda_oe <= 1'b1;
              ptr_q <= shift_q;
              st_q <= rtcs_pkg::RTCS_PTR_ACK;
            end else begin
              sda_oe <= 1'b1;
              ptr_q <= ptr_q + 8'h01;
              st_q <= rtcs_pkg::RTCS_WR_ACK;
            end
          end
        end
        rtcs_pkg::RTCS_ADDR_ACK, rtcs_pkg::RTCS_RD_ACK: begin
          if (scl_rise) begin
            nack_q <= sda_sync_q[1];
          end else if (scl_fall) begin
            if ((st_q == rtcs_pkg::RTCS_ADDR_ACK && read_mode_q)
                || (st_q == rtcs_pkg::RTCS_RD_ACK && !nack_q)) begin
              shift_q <= rd_byte;
              sda_oe <= ~rd_byte[7];
              ptr_q <= ptr_q + 8'h01;
              bit_cnt_q <= 4'h1;
              st_q <= rtcs_pkg::RTCS_RD;
            end else begin
              sda_oe <= 1'b0;
              st_q <= (st_q == rtcs_pkg::RTCS_ADDR_ACK) ? rtcs_pkg::RTCS_PTR
                : rtcs_pkg::RTCS_IDLE;
            end
          end
        end
        rtcs_pkg::RTCS_PTR_ACK, rtcs_pkg::RTCS_WR_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            st_q <= rtcs_pkg::RTCS_WR;
          end
        end
        rtcs_pkg::RTCS_RD: begin
          if (scl_fall) begin
            if (bit_cnt_q == `RTCS_BITS_PER_BYTE) begin
              sda_oe <= 1'b0;
              st_q <= rtcs_pkg::RTCS_RD_ACK;
            end else begin
              sda_oe <= ~shift_q[6];
              shift_q <= {shift_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* File: verification/rtcs_host.sv */
// two-wire bus master model standing in for the host controller
`timescale 1ns/100ps
module rtcs_host (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  //////////////////////////////////////////////
  // quarter of an 80 ns bit; moves land just after a clock edge
  task automatic q();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic start();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask
  // released line reads the pull-up, never the last driven value
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    q();
    scl = 1'b1;
    q();
    s = sda;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
                      output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(last, b);
    ack = !b;
  endtask
endmodule

/* File: verification/rtcs_top_assertions.sv */
// port assertions for the rtc status, restart and watch block
`timescale 1ns/100ps
module rtcs_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic watch_tick,
  input wire logic nonvolatile_write_in_progress,
  input wire logic self_recovery_event,
  input wire logic supply_low_first_event,
  input wire logic supply_low_second_event,
  input wire logic minutes_carry,
  input wire logic logic_restart
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////
  AST_CARRY_PULSE: assert property (minutes_carry |=> !minutes_carry)
    else $error("minutes carry longer than one cycle");
  AST_CARRY_CAUSE: assert property (
    minutes_carry |-> $past(watch_tick) || $past(watch_tick, 2))
    else $error("minutes carry without a tick");
  AST_NO_TICK_NO_CARRY: assert property (!watch_tick [*3] |-> !minutes_carry)
    else $error("minutes carry while ticks are idle");
  // a restart needs a fresh 9 bit byte, so two pulses never sit close
  AST_RESTART_SPACING: assert property (logic_restart |=> !logic_restart [*8])
    else $error("restart pulses too close");
  AST_RELEASE_QUIET: assert property (
    $rose(resetn) |-> !sda_oe && !minutes_carry && !logic_restart)
    else $error("outputs active right after reset");
  // the data line may only move while the clock is low, and is never driven high
  AST_OPEN_DRAIN: assert property ($changed(sda_oe) |-> !scl_i && !sda_o)
    else $error("data pin driven high");
  AST_ACK_HOLD: assert property ($rose(sda_oe) |=> sda_oe [*4])
    else $error("data pin drive dropped early");
endmodule
bind rtcs_top rtcs_checker u_rtcs_checker (.mclk(mclk), .resetn(resetn), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .watch_tick(watch_tick),
  .nonvolatile_write_in_progress(nonvolatile_write_in_progress),
  .self_recovery_event(self_recovery_event), .supply_low_first_event(supply_low_first_event),
  .supply_low_second_event(supply_low_second_event), .minutes_carry(minutes_carry),
  .logic_restart(logic_restart));

/* File: verification/rtcs_top_bench.sv */
// self-checking bench for the rtc status, restart and watch block
`timescale 1ns/100ps
`include "rtcs_consts.svh"
module rtcs_top_bench;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic busy = 1'b0;
  logic [3:0] ev = 4'h0;
  logic scl, host_low, sda_oe, carry, restart, k;
  logic [7:0] n_carry = 8'h00;
  logic [7:0] n_rst = 8'h00;
  logic [7:0] v;
  int bad_count = 0;
  int cmp_count = 0;
  wire sda = !(sda_oe || host_low);
  always #5 mclk = !mclk;
  always @(posedge mclk) begin
    n_carry <= n_carry + {7'h00, carry};
    n_rst <= n_rst + {7'h00, restart};
  end
  rtcs_host u_rtcs_host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(host_low));
  rtcs_top u_rtcs_top (.mclk(mclk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe), .watch_tick(ev[0]), .nonvolatile_write_in_progress(busy),
    .self_recovery_event(ev[1]), .supply_low_first_event(ev[2]),
    .supply_low_second_event(ev[3]), .minutes_carry(carry), .logic_restart(restart));
  //////////////////////////////////////////////
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_rtcs_host.start();
    u_rtcs_host.xfer({`RTCS_DEV_ADDR, 1'b0}, 1'b1, r, k);
    u_rtcs_host.xfer(a, 1'b1, r, k);
    u_rtcs_host.xfer(d, 1'b1, r, k);
    u_rtcs_host.stop();
    chk({7'h00, k}, 8'h01);
  endtask
  task automatic rx(input logic [7:0] a, input logic [7:0] e);
    u_rtcs_host.start();
    u_rtcs_host.xfer({`RTCS_DEV_ADDR, 1'b0}, 1'b1, v, k);
    u_rtcs_host.xfer(a, 1'b1, v, k);
    u_rtcs_host.start();
    u_rtcs_host.xfer({`RTCS_DEV_ADDR, 1'b1}, 1'b1, v, k);
    u_rtcs_host.xfer(8'hFF, 1'b1, v, k);
    u_rtcs_host.stop();
    chk(v, e);
  endtask
  task automatic pulse(input int i);
    @(posedge mclk);
    #1 ev[i] = 1'b1;
    @(posedge mclk);
    #1 ev[i] = 1'b0;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge mclk);
    rx(`RTCS_OFS_STATUS, 8'h20);
    busy = 1'b1;
    rx(`RTCS_OFS_STATUS, 8'hA0);
    rx(`RTCS_OFS_SECONDS, 8'h00);
    wr(`RTCS_OFS_SECONDS, 8'h09);
    pulse(0);
    rx(`RTCS_OFS_SECONDS, 8'h10);
    // host acks the first byte, so the pointer walks on from seconds to minutes
    u_rtcs_host.start();
    u_rtcs_host.xfer({`RTCS_DEV_ADDR, 1'b0}, 1'b1, v, k);
    u_rtcs_host.xfer(`RTCS_OFS_SECONDS, 1'b1, v, k);
    u_rtcs_host.start();
    u_rtcs_host.xfer({`RTCS_DEV_ADDR, 1'b1}, 1'b1, v, k);
    u_rtcs_host.xfer(8'hFF, 1'b0, v, k);
    chk(v, 8'h10);
    u_rtcs_host.xfer(8'hFF, 1'b1, v, k);
    u_rtcs_host.stop();
    chk(v, 8'h00);
    wr(`RTCS_OFS_SECONDS, 8'hD9);
    wr(`RTCS_OFS_MINUTES, 8'hD9);
    rx(`RTCS_OFS_SECONDS, 8'h59);
    rx(`RTCS_OFS_MINUTES, 8'h59);
    pulse(0);
    rx(`RTCS_OFS_SECONDS, 8'h00);
    rx(`RTCS_OFS_MINUTES, 8'h00);
    chk(n_carry, 8'h01);
    pulse(1);
    pulse(2);
    pulse(3);
    rx(`RTCS_OFS_STATUS, 8'hBC);
    wr(`RTCS_OFS_STATUS, 8'h00);
    rx(`RTCS_OFS_STATUS, 8'h80);
    wr(`RTCS_OFS_RESTART, 8'hEF);
    chk(n_rst, 8'h00);
    wr(`RTCS_OFS_RESTART, 8'h10);
    chk(n_rst, 8'h01);
    rx(`RTCS_OFS_STATUS, 8'h90);
    rx(`RTCS_OFS_RESTART, 8'h00);
    // a foreign address must draw no acknowledge
    u_rtcs_host.start();
    u_rtcs_host.xfer({`RTCS_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, v, k);
    u_rtcs_host.stop();
    chk({7'h00, k}, 8'h00);
    finish_test();
  end
  initial begin
    #400000;
    bad_count++;
    finish_test();
  end
endmodule
